/* rtl/lcd_consts.svh */
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

// status value layout
`define LCD_ST_MFR_LSB      0
`define LCD_ST_REV_LSB      4
`define LCD_ST_REF_LSB      8
`define LCD_ST_WID_BIT      11
`define LCD_ST_TYPE_BIT     12
`define LCD_ST_DEN_LSB      13
`define LCD_REF_2X          3'h3
`define LCD_REF_1X          3'h4
`define LCD_REF_Q25X        3'h6
`define LCD_REF_RESERVED    3'h0

// mode register select on bank address
`define LCD_SEL_STD         2'h0
`define LCD_SEL_STATUS      2'h1
`define LCD_SEL_EXT         2'h2

// mode register fields
`define LCD_MR_LAT_LSB      4
`define LCD_MR_BL_LSB       0
`define LCD_MR_RESET        13'h0032
`define LCD_EMR_RESET       13'h0000
`define LCD_RD_LAT_DEFAULT  3'h3
`define LCD_AP_BIT          10

// link clock: 400 ns period sampled by 50 ns system clock
`define LCD_CLK_NS          50
`define LCD_LINK_NS         400
`define LCD_LINK_RATIO      (`LCD_LINK_NS / `LCD_CLK_NS)

`endif

/* rtl/lcd_pkg.sv */
package lcd_pkg;
    typedef enum logic [3:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_BURST_STOP,
        CMD_PRECHARGE,
        CMD_AUTO_REFRESH,
        CMD_SELF_REFRESH,
        CMD_MODE_LOAD,
        CMD_DEEP_POWER_DOWN
    } lcd_cmd_e;

    typedef struct packed {
        logic       cs_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic       cke;
        logic [1:0] ba;
        logic [12:0] addr;
    } lcd_pins_s;
endpackage

/* rtl/lcd_dec_if.sv */
`timescale 1ns/100ps
interface lcd_dec_if;
    import lcd_pkg::*;
    lcd_pins_s pins;
    logic      strobe;
    lcd_cmd_e  cmd;
    logic      cmd_vld;
    modport dec (input pins, input strobe, output cmd, output cmd_vld);
    modport top (output pins, output strobe, input cmd, input cmd_vld);
endinterface

/* rtl/lcd_cmd_decode.sv */
`timescale 1ns/100ps
module lcd_cmd_decode
    import lcd_pkg::*;
(
    input  wire logic clock,
    input  wire logic rstn,
    lcd_dec_if.dec    dif
);
    lcd_cmd_e cmd_d;
    lcd_cmd_e cmd_q;
    logic     vld_d;
    logic     vld_q;

    // =====================================================
    // strobe decode
    always_comb begin
        cmd_d = CMD_NOP;
        vld_d = dif.strobe;
        if (dif.pins.cs_n) begin
            cmd_d = CMD_DESELECT;
        end else begin
            unique case ({dif.pins.ras_n, dif.pins.cas_n, dif.pins.we_n})
                3'h7: cmd_d = CMD_NOP;
                3'h3: cmd_d = CMD_ACTIVATE;
                3'h5: cmd_d = CMD_READ;
                3'h4: cmd_d = CMD_WRITE;
                3'h2: cmd_d = CMD_PRECHARGE;
                3'h0: cmd_d = CMD_MODE_LOAD;
                3'h6: cmd_d = dif.pins.cke ? CMD_BURST_STOP : CMD_DEEP_POWER_DOWN;
                3'h1: cmd_d = dif.pins.cke ? CMD_AUTO_REFRESH : CMD_SELF_REFRESH;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmd_q <= CMD_NOP;
            vld_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            vld_q <= vld_d;
        end
    end

    assign dif.cmd     = cmd_q;
    assign dif.cmd_vld = vld_q;
endmodule

/* rtl/lcd_mode_mem.sv */
`timescale 1ns/100ps
`include "lcd_consts.svh"
module lcd_mode_mem (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_sel,
    input  wire logic [12:0] wr_data,
    output logic      [12:0] std_q,
    output logic      [12:0] ext_q
);
    logic [12:0] std_d;
    logic [12:0] ext_d;

    always_comb begin
        std_d = std_q;
        ext_d = ext_q;
        if (wr_en && wr_sel == `LCD_SEL_STD) begin
            std_d = wr_data;
        end
        if (wr_en && wr_sel == `LCD_SEL_EXT) begin
            ext_d = wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            std_q <= `LCD_MR_RESET;
            ext_q <= `LCD_EMR_RESET;
        end else begin
            std_q <= std_d;
            ext_q <= ext_d;
        end
    end
endmodule

/* rtl/lcd_command_top.sv */
// Function
// - status carries refresh multiplier 2X, 1X, 0.25X
// - reserved status bits read as zero
// - status data uses programmed read latency
// - status read is always two beats
// - only first status beat carries data
// - after restart ignore commands until one no-op or deselect
// - activate decoded and row opened
// - read burst started at bank and column
// - write burst started at bank and column
// - precharge one or all banks
// - mode-load writes standard or extended register
// - burst terminate, or deep power down
// - auto refresh, or self refresh
// - deselect and no-op leave operations unaffected
`timescale 1ns/100ps
`include "lcd_consts.svh"
module lcd_command_top
    import lcd_pkg::*;
#(
    parameter logic [3:0] MFR_ID  = 4'h5, // arbitrary value
    parameter logic [3:0] REV_ID  = 4'h1  // arbitrary value
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        link_clk,
    input  wire logic        link_clk_n,
    input  wire logic        cke,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [1:0]  ba,
    input  wire logic [12:0] addr,
    input  wire logic [2:0]  temp_code,
    output logic      [31:0] dq_out,
    output logic             dq_oe,
    output logic      [3:0]  bank_open,
    output logic             self_refresh,
    output logic             deep_power_down,
    output logic             refresh_pulse,
    output logic             clock_stopped,
    output logic             write_active
);
    // =====================================================
    // pin synchronisers
    lcd_pins_s pins_m_q;
    lcd_pins_s pins_q;
    logic [1:0] clk_m_q;
    logic [1:0] clk_s_q;
    logic       clk_prev_q;
    logic [2:0] temp_m_q;
    logic [2:0] temp_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pins_m_q   <= '0;
            pins_q     <= '0;
            clk_m_q    <= 2'h2;
            clk_s_q    <= 2'h2;
            clk_prev_q <= 1'b0;
            temp_m_q   <= 3'h0;
            temp_q     <= 3'h0;
        end else begin
            pins_m_q   <= '{cs_n, ras_n, cas_n, we_n, cke, ba, addr};
            pins_q     <= pins_m_q;
            clk_m_q    <= {link_clk_n, link_clk};
            clk_s_q    <= clk_m_q;
            clk_prev_q <= clk_s_q[0];
            temp_m_q   <= temp_code;
            temp_q     <= temp_m_q;
        end
    end

    // pins lag the clock edge by the same two stages, so the edge sees settled values
    logic rise;
    assign rise = clk_s_q[0] && !clk_prev_q;

    // =====================================================
    // command decode
    lcd_dec_if dif ();
    assign dif.pins   = pins_q;
    assign dif.strobe = rise;

    lcd_cmd_decode u_dec (
        .clock (clock),
        .rstn  (rstn),
        .dif   (dif)
    );

    // registered address copy aligned with decode output
    logic [1:0]  ba_q;
    logic [12:0] addr_q;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ba_q   <= 2'h0;
            addr_q <= 13'h0;
        end else begin
            ba_q   <= pins_q.ba;
            addr_q <= pins_q.addr;
        end
    end

    // =====================================================
    // clock stop detect: link low, complement high, long idle
    // threshold of 16 needs five bits; four would wrap to zero and trip every low half
    logic [4:0] stop_cnt_d;
    logic [4:0] stop_cnt_q;
    logic       stopped_d;
    logic       stopped_q;
    logic       armed_d;
    logic       armed_q;

    always_comb begin
        stop_cnt_d = stop_cnt_q;
        stopped_d  = stopped_q;
        armed_d    = armed_q;
        if (rise) begin
            stop_cnt_d = 5'h0;
            if (stopped_q) begin
                stopped_d = 1'b0;
                armed_d   = 1'b0;
            end
        end else if (clk_s_q == 2'h2 && pins_q.cke) begin
            if (stop_cnt_q == 5'(`LCD_LINK_RATIO * 2)) begin
                stopped_d = 1'b1;
            end else begin
                stop_cnt_d = stop_cnt_q + 5'h1;
            end
        end
        // first no-op or deselect after restart re-arms command intake
        if (dif.cmd_vld && !armed_q &&
            (dif.cmd == CMD_NOP || dif.cmd == CMD_DESELECT)) begin
            armed_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            stop_cnt_q <= 5'h0;
            stopped_q  <= 1'b0;
            armed_q    <= 1'b1;
        end else begin
            stop_cnt_q <= stop_cnt_d;
            stopped_q  <= stopped_d;
            armed_q    <= armed_d;
        end
    end

    logic take;
    assign take = dif.cmd_vld && armed_q && !deep_power_down;

    // =====================================================
    // mode registers
    logic [12:0] mr_q;
    logic [12:0] emr_q;
    lcd_mode_mem u_mem (
        .clock   (clock),
        .rstn    (rstn),
        .wr_en   (take && dif.cmd == CMD_MODE_LOAD),
        .wr_sel  (ba_q),
        .wr_data (addr_q),
        .std_q   (mr_q),
        .ext_q   (emr_q)
    );

    function automatic logic [2:0] rd_lat(input logic [12:0] mr);
        rd_lat = (mr[`LCD_MR_LAT_LSB +: 3] == 3'h0) ? `LCD_RD_LAT_DEFAULT
                                                     : mr[`LCD_MR_LAT_LSB +: 3];
    endfunction

    function automatic logic [2:0] ref_mult(input logic [2:0] t);
        unique case (t)
            `LCD_REF_2X:   ref_mult = `LCD_REF_2X;
            `LCD_REF_1X:   ref_mult = `LCD_REF_1X;
            `LCD_REF_Q25X: ref_mult = `LCD_REF_Q25X;
            default:       ref_mult = `LCD_REF_1X;
        endcase
    endfunction

    // =====================================================
    // status value; upper bits stay zero
    logic [31:0] status_value;
    always_comb begin
        status_value = 32'h0;
        status_value[`LCD_ST_MFR_LSB +: 4] = MFR_ID;
        status_value[`LCD_ST_REV_LSB +: 4] = REV_ID;
        status_value[`LCD_ST_REF_LSB +: 3] = ref_mult(temp_q);
        status_value[`LCD_ST_WID_BIT]      = 1'b1;
        status_value[`LCD_ST_TYPE_BIT]     = 1'b0;
        status_value[`LCD_ST_DEN_LSB +: 3] = 3'h4;
    end

    // =====================================================
    // bank state, power state, status-select flag, read path
    typedef enum logic [1:0] {RD_IDLE = 2'h0, RD_WAIT = 2'h1, RD_BEAT = 2'h3} lcd_rd_e;

    lcd_rd_e     rd_st_d;
    lcd_rd_e     rd_st_q;
    logic [2:0]  lat_d;
    logic [2:0]  lat_q;
    logic [3:0]  beats_d;
    logic [3:0]  beats_q;
    logic        st_rd_d;
    logic        st_rd_q;
    logic        st_sel_d;
    logic        st_sel_q;
    logic [3:0]  bank_d;
    logic        sr_d;
    logic        dpd_d;
    logic        ref_d;
    logic        wr_d;
    logic [31:0] dq_d;
    logic        oe_d;

    always_comb begin
        rd_st_d  = rd_st_q;
        lat_d    = lat_q;
        beats_d  = beats_q;
        st_rd_d  = st_rd_q;
        st_sel_d = st_sel_q;
        bank_d   = bank_open;
        sr_d     = self_refresh;
        dpd_d    = deep_power_down;
        ref_d    = 1'b0;
        wr_d     = write_active;
        dq_d     = 32'h0;
        oe_d     = 1'b0;
        if (self_refresh && dif.cmd_vld && pins_q.cke) begin
            sr_d = 1'b0;
        end
        if (take) begin
            unique case (dif.cmd)
                CMD_ACTIVATE:  bank_d[ba_q] = 1'b1;
                CMD_PRECHARGE: begin
                    if (addr_q[`LCD_AP_BIT]) begin
                        bank_d = 4'h0;
                    end else begin
                        bank_d[ba_q] = 1'b0;
                    end
                end
                CMD_READ: begin
                    rd_st_d = RD_WAIT;
                    lat_d   = rd_lat(mr_q) - 3'h1;
                    st_rd_d = st_sel_q;
                    beats_d = st_sel_q ? 4'h1 : 4'(1 << mr_q[`LCD_MR_BL_LSB +: 3]) - 4'h1;
                    st_sel_d = 1'b0;
                    wr_d    = 1'b0;
                end
                CMD_WRITE:       wr_d = 1'b1;
                CMD_BURST_STOP: begin
                    rd_st_d = RD_IDLE;
                    wr_d    = 1'b0;
                end
                CMD_DEEP_POWER_DOWN: dpd_d = 1'b1;
                CMD_AUTO_REFRESH:    ref_d = 1'b1;
                CMD_SELF_REFRESH:    sr_d  = 1'b1;
                CMD_MODE_LOAD:       st_sel_d = (ba_q == `LCD_SEL_STATUS);
                default: ;
            endcase
        end
        unique case (rd_st_q)
            RD_IDLE: ;
            RD_WAIT: begin
                if (dif.cmd_vld) begin
                    if (lat_q == 3'h0) begin
                        rd_st_d = RD_BEAT;
                    end else begin
                        lat_d = lat_q - 3'h1;
                    end
                end
            end
            RD_BEAT: begin
                oe_d = 1'b1;
                // first beat carries status, second left zero
                dq_d = (st_rd_q && beats_q == 4'h1) ? status_value : 32'h0;
                if (dif.cmd_vld) begin
                    if (beats_q == 4'h0) begin
                        rd_st_d = RD_IDLE;
                    end else begin
                        beats_d = beats_q - 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rd_st_q         <= RD_IDLE;
            lat_q           <= 3'h0;
            beats_q         <= 4'h0;
            st_rd_q         <= 1'b0;
            st_sel_q        <= 1'b0;
            bank_open       <= 4'h0;
            self_refresh    <= 1'b0;
            deep_power_down <= 1'b0;
            refresh_pulse   <= 1'b0;
            write_active    <= 1'b0;
            dq_out          <= 32'h0;
            dq_oe           <= 1'b0;
            clock_stopped   <= 1'b0;
        end else begin
            rd_st_q         <= rd_st_d;
            lat_q           <= lat_d;
            beats_q         <= beats_d;
            st_rd_q         <= st_rd_d;
            st_sel_q        <= st_sel_d;
            bank_open       <= bank_d;
            self_refresh    <= sr_d;
            deep_power_down <= dpd_d;
            refresh_pulse   <= ref_d;
            write_active    <= wr_d;
            dq_out          <= dq_d;
            dq_oe           <= oe_d;
            clock_stopped   <= stopped_q;
        end
    end
endmodule

/* tb/lcd_ctrl_model.sv */
`timescale 1ns/100ps
module lcd_ctrl_model (
    output logic        link_clk,
    output logic        link_clk_n,
    output logic        cke,
    output logic        cs_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [1:0]  ba,
    output logic [12:0] addr
);
    logic run;
    assign link_clk_n = ~link_clk;
    // ==========
    // link clock, free in phase against the system clock
    initial begin
        run = 1'b1;
        link_clk = 1'b0;
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1f;
        ba = 2'h0;
        addr = 13'h0;
        #137;
        // one fixed period: no frequency change, so timing and refresh stay met
        forever begin
            #200;
            link_clk = run ? ~link_clk : 1'b0;
        end
    end
    // ==========
    // c = {cke, cs_n, ras_n, cas_n, we_n}; released pins carry inverted junk
    task automatic cmd(input logic [4:0] c, input logic [1:0] b, input logic [12:0] a);
        @(negedge link_clk);
        {cke, cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(negedge link_clk);
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = ~c[2:0];
        ba = ~b;
        addr = ~a;
        @(posedge link_clk);
    endtask
    // caller only stops with no burst in flight and banks idle
    task automatic stop();
        @(negedge link_clk);
        run = 1'b0;
        cke = 1'b1;
    endtask
    // restart with a command on the first edge, no no-op before it
    task automatic go(input logic [4:0] c, input logic [1:0] b);
        {cke, cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        run = 1'b1;
        @(negedge link_clk);
        cs_n = 1'b1;
        @(posedge link_clk);
    endtask
endmodule

/* tb/lcd_cmd_checker.sv */
`timescale 1ns/100ps
module lcd_cmd_checker (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        link_clk,
    input wire logic        link_clk_n,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  ba,
    input wire logic [12:0] addr,
    input wire logic [2:0]  temp_code,
    input wire logic [31:0] dq_out,
    input wire logic        dq_oe,
    input wire logic [3:0]  bank_open,
    input wire logic        self_refresh,
    input wire logic        deep_power_down,
    input wire logic        refresh_pulse,
    input wire logic        clock_stopped,
    input wire logic        write_active
);
    // ==========
    // command seen at the last raw link rise, and parked-clock run length
    logic [4:0] lat_q, lat_d;
    logic [1:0] lba_q, lba_d;
    logic       lk_q, lk_d;
    logic [7:0] lowc_q, lowc_d;
    always_comb begin
        lk_d = link_clk;
        lat_d = lat_q;
        lba_d = lba_q;
        if (link_clk && !lk_q) begin
            lat_d = {cke, cs_n, ras_n, cas_n, we_n};
            lba_d = ba;
        end
        lowc_d = 8'h0;
        if (!link_clk && link_clk_n && cke)
            lowc_d = lowc_q + {7'h0, lowc_q != 8'hff};
    end
    always_ff @(posedge clock) begin
        lk_q <= lk_d;
        lat_q <= lat_d;
        lba_q <= lba_d;
        lowc_q <= lowc_d;
    end
    // ==========
    // properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_beat;
        dq_oe [*8];
    endsequence
    sequence s_pulse;
        refresh_pulse ##1 !refresh_pulse;
    endsequence
    a_idle_dq_zero: assert property (!dq_oe |-> dq_out == 32'h0)
        else $error("dq not zero while idle");
    a_beat_holds: assert property ($rose(dq_oe) |-> s_beat)
        else $error("read beat shorter than a link period");
    a_refresh_pulse: assert property (refresh_pulse |-> s_pulse)
        else $error("refresh pulse longer than one cycle");
    a_refresh_cause: assert property (refresh_pulse |-> lat_q[4] && !lat_q[3]
        && !lat_q[1] && lat_q[0])
        else $error("refresh without refresh command");
    a_self_ref_cause: assert property ($rose(self_refresh) |-> !lat_q[4] && !lat_q[3]
        && !lat_q[1] && lat_q[0])
        else $error("self refresh without its command");
    a_power_cause: assert property ($rose(deep_power_down) |-> lat_q == 5'h06)
        else $error("power down without its command");
    a_row_opens: assert property ((bank_open & ~$past(bank_open)) != 4'h0
        |-> lat_q == 5'h13 && (bank_open & ~$past(bank_open)) == (4'h1 << lba_q))
        else $error("row opened without activate");
    a_row_closes: assert property ((~bank_open & $past(bank_open)) != 4'h0
        |-> lat_q == 5'h12)
        else $error("row closed without precharge");
    a_write_cause: assert property ($rose(write_active) |-> lat_q == 5'h14)
        else $error("write without write command");
    a_stop_time: assert property ($rose(clock_stopped) |-> lowc_q >= 8'd16)
        else $error("clock stop seen too early");
    a_stop_quiet: assert property (clock_stopped |-> !dq_oe && !refresh_pulse)
        else $error("activity during clock stop");
endmodule
bind lcd_command_top lcd_cmd_checker lcd_cmd_checker_inst (
    .clock(clock), .rstn(rstn), .link_clk(link_clk), .link_clk_n(link_clk_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .temp_code(temp_code), .dq_out(dq_out), .dq_oe(dq_oe),
    .bank_open(bank_open), .self_refresh(self_refresh),
    .deep_power_down(deep_power_down), .refresh_pulse(refresh_pulse),
    .clock_stopped(clock_stopped), .write_active(write_active));

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
    localparam logic [4:0] C_NOP = 5'h17, C_ACT = 5'h13, C_RD = 5'h15, C_WR = 5'h14;
    localparam logic [4:0] C_BST = 5'h16, C_PRE = 5'h12, C_REF = 5'h11, C_SREF = 5'h01;
    localparam logic [4:0] C_MODE = 5'h10, C_PWR = 5'h06;
    logic clock, rstn, link_clk, link_clk_n, cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0] ba, b;
    logic [12:0] addr;
    logic [2:0] temp_code;
    logic [31:0] dq_out, d0, d1;
    logic dq_oe, self_refresh, deep_power_down, refresh_pulse, clock_stopped, write_active;
    logic [3:0] bank_open, mb;
    int fail_count, compares, rcnt, r0, lat, beats, f, n;

    lcd_command_top #(.MFR_ID(4'h9), .REV_ID(4'h2)) lcd_command_top_inst (
        .clock(clock), .rstn(rstn), .link_clk(link_clk), .link_clk_n(link_clk_n),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .addr(addr), .temp_code(temp_code), .dq_out(dq_out), .dq_oe(dq_oe),
        .bank_open(bank_open), .self_refresh(self_refresh),
        .deep_power_down(deep_power_down), .refresh_pulse(refresh_pulse),
        .clock_stopped(clock_stopped), .write_active(write_active));
    lcd_ctrl_model lcd_ctrl_model_inst (
        .link_clk(link_clk), .link_clk_n(link_clk_n), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

    always #25 clock = ~clock;
    always @(posedge clock) if (refresh_pulse === 1'b1) rcnt++;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmd(input logic [4:0] c, input logic [1:0] bb, input logic [12:0] a);
        lcd_ctrl_model_inst.cmd(c, bb, a);
    endtask
    task automatic rst();
        @(posedge clock);
        #1 rstn = 1'b0;
        repeat (12) @(posedge clock);
        #1 rstn = 1'b1;
        @(posedge clock);
        #1;
        chk({dq_out[21:0], dq_oe, bank_open, self_refresh, deep_power_down, refresh_pulse,
            clock_stopped, write_active}, 32'h0);
        mb = 4'h0;
        lat = 3;
        beats = 4;
    endtask
    // ==========
    // read: first beat index counted in link falling edges after the command
    task automatic rd(input logic [1:0] bb);
        f = 0;
        n = 0;
        cmd(C_RD, bb, 13'h0);
        for (int k = 2; k < 16; k++) begin
            @(negedge link_clk);
            if (dq_oe === 1'b1) begin
                if (n == 0) f = k;
                if (n == 0) d0 = dq_out;
                if (n == 1) d1 = dq_out;
                n++;
            end
        end
    endtask
    function automatic logic [31:0] st_exp(input int t);
        int m;
        m = (t == 3 || t == 4 || t == 6) ? t : 4;
        return {16'h0, 3'h4, 1'b0, 1'b1, 3'(m), 4'h2, 4'h9};
    endfunction
    task automatic summarize();
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #1_000_000;
        fail_count++;
        summarize();
    end

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        temp_code = 3'h4;
        fail_count = 0;
        compares = 0;
        rcnt = 0;
        void'($urandom(32'h9171d781));
        rst();
        cmd(5'h1b, 2'h1, 13'h0);
        chk({28'h0, bank_open}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            b = 2'($urandom_range(3));
            cmd(C_ACT, b, 13'($urandom()));
            mb[b] = 1'b1;
            chk({28'h0, bank_open}, {28'h0, mb});
        end
        cmd(C_WR, b, 13'h0);
        chk({31'h0, write_active}, 32'h1);
        cmd(C_NOP, 2'h0, 13'h0);
        chk({31'h0, write_active}, 32'h1);
        cmd(C_BST, 2'h0, 13'h0);
        chk({31'h0, write_active}, 32'h0);
        rd(b);
        chk(32'(f), 32'(lat + 2));
        chk(32'(n), 32'(beats));
        cmd(C_PRE, b, 13'h0);
        mb[b] = 1'b0;
        chk({28'h0, bank_open}, {28'h0, mb});
        cmd(C_PRE, 2'h0, 13'h400);
        chk({28'h0, bank_open}, 32'h0);
        // latency 2, two-beat bursts
        cmd(C_MODE, 2'h0, 13'h0021);
        lat = 2;
        beats = 2;
        rd(2'h0);
        chk(32'(f), 32'(lat + 2));
        chk(32'(n), 32'(beats));
        // ==========
        // status value for every multiplier code; banks idle, one no-op between mode load and read
        for (int t = 0; t < 8; t++) begin
            @(posedge clock);
            #1 temp_code = 3'(t);
            cmd(C_MODE, 2'h1, 13'h0);
            cmd(C_NOP, 2'h0, 13'h0);
            rd(2'($urandom_range(3)));
            chk(d0, st_exp(t));
            chk(d1, 32'h0);
            chk(32'(n), 32'h2);
            chk(32'(f), 32'(lat + 2));
        end
        r0 = rcnt;
        cmd(C_REF, 2'h0, 13'h0);
        chk(32'(rcnt - r0), 32'h1);
        // ==========
        // clock stop; the first command after restart comes before any no-op
        lcd_ctrl_model_inst.stop();
        repeat (24) @(posedge clock);
        #1;
        chk({31'h0, clock_stopped}, 32'h1);
        lcd_ctrl_model_inst.go(C_ACT, 2'h3);
        chk({28'h0, bank_open}, 32'h0);
        cmd(C_NOP, 2'h0, 13'h0);
        cmd(C_ACT, 2'h3, 13'h0);
        chk({28'h0, bank_open}, 32'h8);
        cmd(C_PRE, 2'h0, 13'h400);
        cmd(C_SREF, 2'h0, 13'h0);
        chk({31'h0, self_refresh}, 32'h1);
        rst();
        cmd(C_PWR, 2'h0, 13'h0);
        chk({31'h0, deep_power_down}, 32'h1);
        rst();
        summarize();
    end
endmodule
